// ==== rtl/aimc_pkg.sv ====
// Shared constants and carriers of the converter input selector control.
// Assumes a single 250 MHz APB clock; analog parts sit outside the RTL.
package aimc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned MAX_RATE_SPS    = 100000;
  localparam int unsigned CONV_PERIOD_NS  = 1000000000 / MAX_RATE_SPS;
  localparam int unsigned CONV_MIN_CYCLES = (CONV_PERIOD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RES_BITS        = 10;
  localparam int unsigned TRACK_TICKS     = 3;
  localparam int unsigned SAR_STEPS       = TRACK_TICKS + RES_BITS;
  localparam int unsigned SAR_DIV_DEF     = (CONV_MIN_CYCLES + SAR_STEPS - 1) / SAR_STEPS;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_REF  = 8'h04;
  localparam logic [7:0] ADDR_SEL  = 8'h08;
  localparam logic [7:0] ADDR_PAIR = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  localparam logic [7:0] ADDR_DATA = 8'h18;

  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_START_BIT = 1;
  localparam int unsigned REF_BIAS_BIT   = 0;
  localparam int unsigned STAT_DONE_BIT  = 0;

  localparam logic [3:0] SEL_RST   = 4'h0;
  localparam logic [3:0] PAIR_RST  = 4'h0;
  localparam logic [3:0] TEMP_SRC  = 4'h8;
  localparam logic [9:0] CODE_MID  = 10'h200;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    AIMC_IDLE  = 2'b00,
    AIMC_TRACK = 2'b01,
    AIMC_CONV  = 2'b10
  } aimc_fsm_t;

  typedef struct packed {
    logic [3:0] pos;
    logic [2:0] neg;
    logic       diff;
    logic       temp;
  } aimc_mux_t;

  typedef struct packed {
    logic        en;
    logic        bias;
    logic [3:0]  chsel;
    logic [3:0]  pair;
    logic        mask;
    logic        done;
    aimc_fsm_t   fsm;
    logic [11:0] div;
    logic [3:0]  tick;
    logic [9:0]  code;
    logic [9:0]  result;
    logic        diff_cap;
    logic        cmp_s1;
    logic        cmp_s2;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    aimc_mux_t   mux;
    logic        th;
    logic        pwr;
    logic        shdn;
    logic        irq;
  } aimc_state_t;

endpackage : aimc_pkg

// ==== rtl/aimc_top.sv ====
// Converter subsystem control: enable gating, input selector, SAR sequencer.
// Assumes an APB master on pclk and an external comparator and DAC.
`timescale 1ns/100ps
module aimc_top
  import aimc_pkg::*;
#(
  parameter int unsigned SAR_DIV = SAR_DIV_DEF
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog front end
  input  wire logic        cmp_in,
  output aimc_mux_t        mux_sel,
  output logic      [9:0]  dac_code,
  output logic             track_hold,
  output logic             conv_power,
  output logic             conv_shutdown,
  output logic             bias_enable,
  // Interrupt
  output logic             irq
);

  // ****************************************
  // State
  // ****************************************
  aimc_state_t q;
  aimc_state_t d;
  logic        busy;
  logic        acc_req;
  logic        acc_wr;
  logic        sar_tick;
  logic        start;
  logic        done_set;
  logic        hit;
  logic [31:0] rdata;
  logic [9:0]  code_n;

  assign busy     = (q.fsm != AIMC_IDLE);
  assign acc_req  = psel & penable & ~q.pready;
  assign acc_wr   = psel & penable & q.pready & pwrite;
  // SAR_DIV below 3 judges a stale comparator through the synchroniser
  assign sar_tick = (q.div == 12'(SAR_DIV - 1));

  // ****************************************
  // Read decode
  // ****************************************
  always_comb begin
    rdata = 32'h0000_0000;
    hit   = 1'b1;
    if (paddr == ADDR_CTRL) begin
      rdata[CTRL_EN_BIT]    = q.en;
      rdata[CTRL_START_BIT] = busy;
    end else if (paddr == ADDR_REF) begin
      rdata[REF_BIAS_BIT] = q.bias;
    end else if (paddr == ADDR_SEL) begin
      rdata[3:0] = q.chsel;
    end else if (paddr == ADDR_PAIR) begin
      rdata[3:0] = q.pair;
    end else if (paddr == ADDR_STAT) begin
      rdata[STAT_DONE_BIT] = q.done;
    end else if (paddr == ADDR_MASK) begin
      rdata[STAT_DONE_BIT] = q.mask;
    end else if (paddr == ADDR_DATA) begin
      rdata[9:0] = q.result;
    end else begin
      hit = 1'b0;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d        = q;
    start    = 1'b0;
    done_set = 1'b0;
    code_n   = q.code;
    d.cmp_s1 = cmp_in;
    d.cmp_s2 = q.cmp_s1;
    // One wait state so read data comes from a flop
    d.pready  = acc_req;
    d.prdata  = acc_req ? rdata : 32'h0000_0000;
    d.pslverr = acc_req & ~hit;
    if (acc_wr) begin
      if (paddr == ADDR_CTRL) begin
        d.en  = pwdata[CTRL_EN_BIT];
        start = pwdata[CTRL_START_BIT];
      end else if (paddr == ADDR_REF) begin
        d.bias = pwdata[REF_BIAS_BIT];
      end else if (paddr == ADDR_SEL) begin
        d.chsel = pwdata[3:0];
      end else if (paddr == ADDR_PAIR) begin
        d.pair = pwdata[3:0];
      end else if (paddr == ADDR_STAT) begin
        if (pwdata[STAT_DONE_BIT]) begin
          d.done = 1'b0;
        end
      end else if (paddr == ADDR_MASK) begin
        d.mask = pwdata[STAT_DONE_BIT];
      end
    end
    // SAR step divider caps the sample rate
    if (busy && !sar_tick) begin
      d.div = q.div + 12'h001;
    end else begin
      d.div = 12'h000;
    end
    case (q.fsm)
      AIMC_IDLE: begin
        if (start && q.en) begin
          d.fsm      = AIMC_TRACK;
          d.tick     = 4'h0;
          d.th       = 1'b1;
          d.diff_cap = q.mux.diff;
        end
      end
      AIMC_TRACK: begin
        if (sar_tick) begin
          if (q.tick == 4'(TRACK_TICKS - 1)) begin
            d.fsm  = AIMC_CONV;
            d.th   = 1'b0;
            d.tick = 4'(RES_BITS - 1);
            d.code = CODE_MID;
          end else begin
            d.tick = q.tick + 4'h1;
          end
        end
      end
      AIMC_CONV: begin
        if (sar_tick) begin
          if (!q.cmp_s2) begin
            code_n[q.tick] = 1'b0;
          end
          d.code = code_n;
          if (q.tick == 4'h0) begin
            // Offset binary becomes two's complement by flipping the MSB
            d.result = q.diff_cap ? {~code_n[9], code_n[8:0]} : code_n;
            d.fsm    = AIMC_IDLE;
            done_set = 1'b1;
          end else begin
            d.tick              = q.tick - 4'h1;
            d.code[q.tick - 4'h1] = 1'b1;
          end
        end
      end
      default: begin
        d.fsm = AIMC_IDLE;
      end
    endcase
    // Disable aborts at once; the busy fall still flags done
    if (!d.en) begin
      d.fsm  = AIMC_IDLE;
      d.th   = 1'b0;
      d.code = 10'h000;
      d.div  = 12'h000;
      if (busy) begin
        done_set = 1'b1;
      end
    end
    // Hardware set wins over a same-cycle clear
    if (done_set) begin
      d.done = 1'b1;
    end
    // Selector follows the registers live, even mid-conversion
    if (d.chsel[3]) begin
      d.mux = '{pos: TEMP_SRC, neg: 3'h0, diff: 1'b0, temp: 1'b1};
    end else if (d.pair[d.chsel[2:1]]) begin
      d.mux.pos  = {1'b0, d.chsel[2:1], 1'b0};
      d.mux.neg  = {d.chsel[2:1], 1'b1};
      d.mux.diff = 1'b1;
      d.mux.temp = 1'b0;
    end else begin
      d.mux = '{pos: {1'b0, d.chsel[2:0]}, neg: 3'h0, diff: 1'b0, temp: 1'b0};
    end
    d.pwr  = d.en;
    d.shdn = ~d.en;
    d.irq  = d.done & d.mask;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q       <= '0;
      q.chsel <= SEL_RST;
      q.pair  <= PAIR_RST;
      q.fsm   <= AIMC_IDLE;
      q.shdn  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata        = q.prdata;
  assign pready        = q.pready;
  assign pslverr       = q.pslverr;
  assign mux_sel       = q.mux;
  assign dac_code      = q.code;
  assign track_hold    = q.th;
  assign conv_power    = q.pwr;
  assign conv_shutdown = q.shdn;
  assign bias_enable   = q.bias;
  assign irq           = q.irq;

  // ****************************************
  // Assertions
  // ****************************************
  logic [15:0] ast_cnt;
  logic        wr_ctrl;
  logic        wr_sel;
  logic        wr_pair;

  assign wr_ctrl = acc_wr && (paddr == ADDR_CTRL);
  assign wr_sel  = acc_wr && (paddr == ADDR_SEL);
  assign wr_pair = acc_wr && (paddr == ADDR_PAIR);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ast_cnt <= 16'h0000;
    end else begin
      ast_cnt <= busy ? ast_cnt + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PWR_FOLLOWS_EN: assert property (wr_ctrl |=> conv_power == $past(pwdata[CTRL_EN_BIT]))
    else $error("power does not follow enable write");
  AST_SHUTDOWN: assert property (!conv_power |-> conv_shutdown && !track_hold && !busy)
    else $error("subsystem active while disabled");
  // Rate cap only meaningful at the default divider
  AST_CONV_LEN: assert property ($fell(busy) && conv_power |->
    ast_cnt == 16'(SAR_STEPS * SAR_DIV)
    && (SAR_DIV != SAR_DIV_DEF || ast_cnt >= 16'(CONV_MIN_CYCLES)))
    else $error("conversion length wrong");
  AST_TEMP_SEL: assert property (q.chsel[3] |-> mux_sel.temp && mux_sel.pos == TEMP_SRC)
    else $error("temperature sensor not selected");
  AST_PAIR_DIFF: assert property (!q.chsel[3] && q.pair[q.chsel[2:1]] |-> mux_sel.diff
    && mux_sel.pos == {1'b0, q.chsel[2:1], 1'b0} && mux_sel.neg == {q.chsel[2:1], 1'b1})
    else $error("differential pair routed wrongly");
  AST_PAIR_SE: assert property (!q.chsel[3] && !q.pair[q.chsel[2:1]] |->
    !mux_sel.diff && !mux_sel.temp && mux_sel.pos == {1'b0, q.chsel[2:0]})
    else $error("single-ended input routed wrongly");
  AST_RESET_SE: assert property (@(posedge pclk) disable iff (1'b0)
    $rose(presetn) |-> q.pair == PAIR_RST && !mux_sel.diff)
    else $error("pairs not single-ended after reset");
  AST_PAIR_ANYTIME: assert property (wr_pair |=> q.pair == $past(pwdata[3:0]))
    else $error("pairing write lost");
  AST_SEL_SEPARATE: assert property (wr_sel |=> q.chsel == $past(pwdata[3:0])
    && $stable(q.pair))
    else $error("channel write disturbed pairing");
  AST_TWOS_COMP: assert property ($fell(busy) && conv_power |->
    (q.diff_cap ? q.result == {~dac_code[9], dac_code[8:0]} : q.result == dac_code))
    else $error("result format wrong");
  AST_DONE_ON_FALL: assert property ($fell(busy) |-> q.done)
    else $error("busy fall did not set done");
  AST_TRACK_ON_START: assert property ($rose(busy) |-> track_hold)
    else $error("tracking not started with busy");

  COV_DIFF_CONV: cover property ($fell(busy) && conv_power && q.diff_cap);
  COV_TEMP_CONV: cover property ($fell(busy) && conv_power && mux_sel.temp);
  COV_ABORT: cover property ($fell(busy) && !conv_power);
  COV_IRQ: cover property ($rose(irq));

endmodule : aimc_top

// ==== verification/aimc_top_test.sv ====
// Self-checking bench for the converter input selector control.
// Assumes aimc_pkg and aimc_top compiled first; bench acts as APB master and comparator.
`timescale 1ns/100ps
module aimc_top_test;
  import aimc_pkg::*;

  // ****************************************
  // Signals and design
  // ****************************************
  // Registered comparator plus the design's synchroniser need four cycles per step
  localparam int unsigned DIV = 4;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cmp_in;
  aimc_mux_t   mux_sel;
  logic [9:0]  dac_code;
  logic        track_hold;
  logic        conv_power;
  logic        conv_shutdown;
  logic        bias_enable;
  logic        irq;
  logic [9:0]  level;
  logic [31:0] r;
  logic        e;
  int          n_mismatch;
  int          total_checks;
  int          th_cnt;

  aimc_top #(.SAR_DIV(DIV)) aimc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_in(cmp_in), .mux_sel(mux_sel),
    .dac_code(dac_code), .track_hold(track_hold), .conv_power(conv_power),
    .conv_shutdown(conv_shutdown), .bias_enable(bias_enable), .irq(irq));

  always #2 pclk = ~pclk;

  // Ideal comparator against a fixed input level
  always @(posedge pclk) begin
    cmp_in <= (level >= dac_code);
    if (track_hold === 1'b1) begin
      th_cnt++;
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task stop_test;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      stop_test();
    end
    // Let the commit edge land before callers look at outputs
    #1;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask : rd_chk

  function automatic aimc_mux_t exp_mux(input logic [3:0] p, input logic [3:0] c);
    aimc_mux_t m;
    m = '0;
    m.temp = c[3];
    m.diff = !c[3] && p[c[2:1]];
    m.pos  = c[3] ? TEMP_SRC : (m.diff ? {c[3:1], 1'b0} : c);
    m.neg  = m.diff ? {c[2:1], 1'b1} : 3'h0;
    return m;
  endfunction : exp_mux

  task convert(input logic [9:0] v, input logic [9:0] exp);
    int n;
    level = v;
    th_cnt = 0;
    wr(ADDR_CTRL, 32'h3);
    rd_chk(ADDR_CTRL, 32'h3);
    n = 0;
    do begin
      apb(1'b0, ADDR_STAT, 32'h0, r, e);
      n++;
    end while (r[0] !== 1'b1 && n < 40);
    if (r[0] !== 1'b1) begin
      n_mismatch++;
      stop_test();
    end
    rd_chk(ADDR_CTRL, 32'h1);
    rd_chk(ADDR_DATA, {22'h0, exp});
    chk(th_cnt, 3 * DIV);
  endtask : convert

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    aimc_mux_t m;
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    level = 10'h000;
    n_mismatch = 0;
    total_checks = 0;
    repeat (4) @(posedge pclk);
    chk({conv_shutdown, conv_power, bias_enable, irq, track_hold}, 5'h10);
    chk({mux_sel, dac_code}, 19'h0);
    presetn <= 1'b1;
    rd_chk(ADDR_PAIR, 32'h0);
    rd_chk(ADDR_SEL, 32'h0);
    wr(ADDR_CTRL, 32'h2);
    rd_chk(ADDR_CTRL, 32'h0);
    chk(conv_shutdown, 1'b1);
    wr(ADDR_REF, 32'h1);
    chk(bias_enable, 1'b1);
    wr(ADDR_CTRL, 32'h1);
    chk({conv_power, conv_shutdown}, 2'b10);
    apb(1'b0, 8'h1C, 32'h0, r, e);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    for (int p = 0; p < 16; p++) begin
      wr(ADDR_PAIR, p);
      rd_chk(ADDR_PAIR, p);
      for (int c = 0; c < 16; c++) begin
        wr(ADDR_SEL, c);
        m = mux_sel;
        if (m.diff !== 1'b1) begin
          m.neg = 3'h0;
        end
        chk(m, exp_mux(p[3:0], c[3:0]));
      end
    end
    wr(ADDR_MASK, 32'h1);
    wr(ADDR_PAIR, 32'h0);
    wr(ADDR_SEL, 32'h3);
    convert(10'h2A5, 10'h2A5);
    chk(irq, 1'b1);
    wr(ADDR_STAT, 32'h1);
    chk(irq, 1'b0);
    wr(ADDR_PAIR, 32'h1);
    wr(ADDR_SEL, 32'h0);
    convert(10'h05A, 10'h25A);
    wr(ADDR_STAT, 32'h1);
    wr(ADDR_MASK, 32'h0);
    wr(ADDR_PAIR, 32'h0);
    wr(ADDR_SEL, 32'h8);
    convert(10'h3FF, 10'h3FF);
    chk(irq, 1'b0);
    wr(ADDR_STAT, 32'h1);
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_CTRL, 32'h0);
    chk({conv_shutdown, conv_power, dac_code}, 12'h800);
    rd_chk(ADDR_STAT, 32'h1);
    rd_chk(ADDR_DATA, 32'h3FF);
    stop_test();
  end
endmodule : aimc_top_test
